// ### design/crt_unit.sv
// Coprocessor register transfer unit with internal control coproc routing
//
// Functional notes
// - Other coprocessor numbers take undefined trap
// - Execute only when condition holds
// - Flag load from transferred bits 31 to 28
// - Flag load leaves PC and others alone
// - Stored PC value is address plus 12
// - Internal coproc transfer takes three cycles
// - Direction bit selects move to core
// - Coproc number field selects target
// - Internal control coproc fifteen via transfers
// - Opcode and register fields passed uninterpreted
// - Other move to core transfers trap
// - Reserved undefined pattern takes trap
// - Only registers 0 to 7 serviced
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module crt_unit (
  input  wire logic        clk,           // Core clock, 40 MHz
  input  wire logic        nrst,          // Asynchronous reset, active low
  // Instruction issue
  input  wire logic        instr_valid,   // Coprocessor class instruction offered
  output logic             instr_ready,   // Unit idle and accepting
  input  wire logic [31:0] instr_word,    // Instruction word
  input  wire logic [31:0] instr_addr,    // Instruction address
  input  wire logic [31:0] core_rd_value, // Named core register value
  input  wire logic [3:0]  core_flags,    // Current flags
  // Results to core
  output logic             xfer_done,     // Instruction finished, pulse
  output logic             undef_trap,    // Take undefined trap, pulse
  output logic             core_wr_en,    // Write core register, pulse
  output logic [3:0]       core_wr_idx,   // Core register index
  output logic [31:0]      core_wr_data,  // Core register data
  output logic             flags_wr_en,   // Load flags, pulse
  output logic [3:0]       flags_wr_data, // New flags
  // Internal control coprocessor
  output logic             cp15_rd_en,    // Read strobe
  output logic             cp15_wr_en,    // Write strobe
  output logic [3:0]       cp15_reg,      // First coproc register
  output logic [2:0]       cp15_opc,      // Operation code field
  output logic [2:0]       cp15_var,      // Operation variant field
  output logic [3:0]       cp15_crm,      // Second coproc register
  output logic [31:0]      cp15_wdata,    // Data to coproc
  input  wire logic [31:0] cp15_rdata,    // Data from coproc
  // APB slave
  input  wire logic        psel,          // Select
  input  wire logic        penable,       // Access phase
  input  wire logic        pwrite,        // Write
  input  wire logic [7:0]  paddr,         // Byte address
  input  wire logic [31:0] pwdata,        // Write data
  output logic [31:0]      prdata,        // Read data
  output logic             pready,        // Ready
  output logic             pslverr,       // Error on unmapped address
  output logic             irq            // Level interrupt
);

  // Sequencer state
  crt_pkg::crt_state_t state;       // Current state
  crt_pkg::crt_state_t next_state;  // Next state
  logic [31:0] ins, next_ins;       // Captured instruction
  logic [31:0] rval, next_rval;     // Value from the coprocessor
  logic        resp_trap, next_resp_trap;  // Pending response is a trap
  logic        resp_skip, next_resp_skip;  // Pending response is a skip
  // Next values of the registered outputs
  logic        next_instr_ready, next_xfer_done, next_undef_trap;
  logic        next_core_wr_en, next_flags_wr_en, next_cp15_rd_en, next_cp15_wr_en;
  logic [3:0]  next_core_wr_idx, next_flags_wr_data, next_cp15_reg, next_cp15_crm;
  logic [2:0]  next_cp15_opc, next_cp15_var;
  logic [31:0] next_core_wr_data, next_cp15_wdata;

  // Register file
  logic [31:0] ctrl, next_ctrl;            // Control
  logic [2:0]  int_stat, next_int_stat;    // Sticky events
  logic [2:0]  int_mask, next_int_mask;    // Event mask
  logic [31:0] last_trap, next_last_trap;  // Last trapped instruction
  logic [31:0] xfer_cnt, next_xfer_cnt;    // Serviced transfers
  logic [31:0] next_prdata;                // Read data for the completing edge
  logic        next_pready, next_pslverr, next_irq;  // Bus and interrupt next values

  // Decode helpers
  logic        cond_pass;           // Condition holds for offered word
  logic        accept;              // Instruction taken this cycle
  logic        apb_fire;            // APB access completes this edge
  logic        ev_trap, ev_done, ev_skip;  // Trap, done and skip events this cycle

  // Register transfer class test
  function automatic logic is_xfer(input logic [31:0] w);
    is_xfer = (w[crt_pkg::CLASS_MSB:crt_pkg::CLASS_LSB] == crt_pkg::CLASS_COPROC)
              && w[crt_pkg::XFER_BIT];
  endfunction

  // Reserved undefined pattern test
  function automatic logic is_undef(input logic [31:0] w);
    is_undef = (w[crt_pkg::UND_MSB:crt_pkg::UND_LSB] == crt_pkg::CLASS_UNDEF)
               && w[crt_pkg::XFER_BIT];
  endfunction

  // Transfer serviced by the internal coproc in hardware
  function automatic logic is_hw(input logic [31:0] w, input logic en);
    is_hw = en
            && (w[crt_pkg::CPN_MSB:crt_pkg::CPN_LSB] == crt_pkg::CP_INTERNAL)
            && (w[crt_pkg::CRN_MSB:crt_pkg::CRN_LSB] <= crt_pkg::CP15_REG_LIMIT);
  endfunction

  // Condition evaluation on the offered word
  crt_cond u_cond (
    .cond  (instr_word[crt_pkg::COND_MSB:crt_pkg::COND_LSB]),
    .flags (core_flags),
    .pass  (cond_pass)
  );

  assign accept   = instr_valid && instr_ready;
  assign apb_fire = psel && penable && pready;

  // Sequencer next values
  always_comb begin
    next_state         = state;
    next_ins           = ins;
    next_rval          = rval;
    next_resp_trap     = resp_trap;
    next_resp_skip     = resp_skip;
    next_xfer_done     = 1'b0;
    next_undef_trap    = 1'b0;
    next_core_wr_en    = 1'b0;
    next_core_wr_idx   = core_wr_idx;
    next_core_wr_data  = core_wr_data;
    next_flags_wr_en   = 1'b0;
    next_flags_wr_data = flags_wr_data;
    next_cp15_rd_en    = 1'b0;
    next_cp15_wr_en    = 1'b0;
    next_cp15_reg      = cp15_reg;
    next_cp15_opc      = cp15_opc;
    next_cp15_var      = cp15_var;
    next_cp15_crm      = cp15_crm;
    next_cp15_wdata    = cp15_wdata;
    ev_trap            = 1'b0;
    ev_done            = 1'b0;
    ev_skip            = 1'b0;
    case (state)
      crt_pkg::CRT_IDLE: begin
        if (accept) begin
          next_ins       = instr_word;
          next_resp_trap = 1'b0;
          next_resp_skip = 1'b0;
          if (!cond_pass) begin
            next_resp_skip = 1'b1;
            next_state     = crt_pkg::CRT_RESP;
          end else if (is_undef(instr_word)) begin
            next_resp_trap = 1'b1;
            next_state     = crt_pkg::CRT_RESP;
          end else if (is_xfer(instr_word) && is_hw(instr_word, ctrl[crt_pkg::CTRL_HW_EN])) begin
            next_state = crt_pkg::CRT_EX1;
            // Fields handed over untouched
            next_cp15_reg   = instr_word[crt_pkg::CRN_MSB:crt_pkg::CRN_LSB];
            next_cp15_opc   = instr_word[crt_pkg::OPC_MSB:crt_pkg::OPC_LSB];
            next_cp15_var   = instr_word[crt_pkg::VAR_MSB:crt_pkg::VAR_LSB];
            next_cp15_crm   = instr_word[crt_pkg::CRM_MSB:crt_pkg::CRM_LSB];
            next_cp15_rd_en = instr_word[crt_pkg::DIR_BIT];
            next_cp15_wr_en = !instr_word[crt_pkg::DIR_BIT];
            next_cp15_wdata = (instr_word[crt_pkg::RD_MSB:crt_pkg::RD_LSB] == crt_pkg::PC_INDEX)
                              ? instr_addr + crt_pkg::PC_STORE_OFFSET : core_rd_value;
          end else begin
            // Other coprocessors, registers and classes go to software
            next_resp_trap = 1'b1;
            next_state     = crt_pkg::CRT_RESP;
          end
        end
      end
      crt_pkg::CRT_EX1: begin
        // Coproc strobe visible this cycle, capture its answer
        next_rval  = cp15_rdata;
        next_state = crt_pkg::CRT_EX2;
      end
      crt_pkg::CRT_EX2: begin
        // Prepare write back for the final cycle
        next_state = crt_pkg::CRT_EX3;
        next_xfer_done = 1'b1;
        if (ins[crt_pkg::DIR_BIT]) begin
          if (ins[crt_pkg::RD_MSB:crt_pkg::RD_LSB] == crt_pkg::PC_INDEX) begin
            // Only the top four bits reach the flags
            next_flags_wr_en   = 1'b1;
            next_flags_wr_data = rval[31:28];
          end else begin
            next_core_wr_en   = 1'b1;
            next_core_wr_idx  = ins[crt_pkg::RD_MSB:crt_pkg::RD_LSB];
            next_core_wr_data = rval;
          end
        end
      end
      crt_pkg::CRT_EX3: begin
        // Write back and done pulses shown now
        ev_done    = 1'b1;
        next_state = crt_pkg::CRT_IDLE;
      end
      crt_pkg::CRT_RESP: begin
        // Trap or skip pulse shown now, no core write
        ev_trap    = resp_trap;
        ev_skip    = resp_skip;
        next_state = crt_pkg::CRT_IDLE;
      end
      default: begin
        next_state = crt_pkg::CRT_IDLE;
      end
    endcase
    // Response pulses for the response state
    if (next_state == crt_pkg::CRT_RESP) begin
      next_undef_trap = next_resp_trap;
      next_xfer_done  = 1'b1;
    end
    next_instr_ready = (next_state == crt_pkg::CRT_IDLE);
  end

  // Sequencer registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state         <= crt_pkg::CRT_IDLE;
      ins           <= 32'h0000_0000;
      rval          <= 32'h0000_0000;
      resp_trap     <= 1'b0;
      resp_skip     <= 1'b0;
      instr_ready   <= 1'b0;
      xfer_done     <= 1'b0;
      undef_trap    <= 1'b0;
      core_wr_en    <= 1'b0;
      core_wr_idx   <= 4'h0;
      core_wr_data  <= 32'h0000_0000;
      flags_wr_en   <= 1'b0;
      flags_wr_data <= 4'h0;
      cp15_rd_en    <= 1'b0;
      cp15_wr_en    <= 1'b0;
      cp15_reg      <= 4'h0;
      cp15_opc      <= 3'h0;
      cp15_var      <= 3'h0;
      cp15_crm      <= 4'h0;
      cp15_wdata    <= 32'h0000_0000;
    end else begin
      state         <= next_state;
      ins           <= next_ins;
      rval          <= next_rval;
      resp_trap     <= next_resp_trap;
      resp_skip     <= next_resp_skip;
      instr_ready   <= next_instr_ready;
      xfer_done     <= next_xfer_done;
      undef_trap    <= next_undef_trap;
      core_wr_en    <= next_core_wr_en;
      core_wr_idx   <= next_core_wr_idx;
      core_wr_data  <= next_core_wr_data;
      flags_wr_en   <= next_flags_wr_en;
      flags_wr_data <= next_flags_wr_data;
      cp15_rd_en    <= next_cp15_rd_en;
      cp15_wr_en    <= next_cp15_wr_en;
      cp15_reg      <= next_cp15_reg;
      cp15_opc      <= next_cp15_opc;
      cp15_var      <= next_cp15_var;
      cp15_crm      <= next_cp15_crm;
      cp15_wdata    <= next_cp15_wdata;
    end
  end

  // Register file and APB next values
  always_comb begin
    next_ctrl      = ctrl;
    next_int_mask  = int_mask;
    next_last_trap = last_trap;
    next_xfer_cnt  = xfer_cnt;
    next_int_stat  = int_stat;
    next_prdata    = prdata;
    next_pslverr   = 1'b0;
    // One wait state: ready raised in second access cycle
    next_pready    = psel && penable && !pready;
    if (psel && penable && !pready) begin
      // Read data and error prepared for the completing edge
      if (paddr == crt_pkg::OFF_CTRL) begin
        next_prdata = ctrl;
      end else if (paddr == crt_pkg::OFF_INT_STAT) begin
        next_prdata = {29'h0000_0000, int_stat};
      end else if (paddr == crt_pkg::OFF_INT_MASK) begin
        next_prdata = {29'h0000_0000, int_mask};
      end else if (paddr == crt_pkg::OFF_LAST_TRAP) begin
        next_prdata = last_trap;
      end else if (paddr == crt_pkg::OFF_XFER_CNT) begin
        next_prdata = xfer_cnt;
      end else begin
        next_prdata  = 32'h0000_0000;
        next_pslverr = 1'b1;
      end
    end
    // Writes take effect on the completing edge
    if (apb_fire && pwrite) begin
      if (paddr == crt_pkg::OFF_CTRL) begin
        next_ctrl = {31'h0000_0000, pwdata[crt_pkg::CTRL_HW_EN]};
      end else if (paddr == crt_pkg::OFF_INT_STAT) begin
        next_int_stat = int_stat & ~pwdata[crt_pkg::EV_W-1:0];
      end else if (paddr == crt_pkg::OFF_INT_MASK) begin
        next_int_mask = pwdata[crt_pkg::EV_W-1:0];
      end
    end
    // Hardware events win over a clear in the same cycle
    if (ev_trap) begin
      next_int_stat[crt_pkg::EV_TRAP] = 1'b1;
      next_last_trap = ins;
    end
    if (ev_done) begin
      next_int_stat[crt_pkg::EV_DONE] = 1'b1;
      next_xfer_cnt = xfer_cnt + 32'h0000_0001;
    end
    if (ev_skip) begin
      next_int_stat[crt_pkg::EV_SKIP] = 1'b1;
    end
    next_irq = |(next_int_stat & next_int_mask);
  end

  // Register file and APB registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl      <= crt_pkg::CTRL_RST;
      int_stat  <= 3'h0;
      int_mask  <= crt_pkg::MASK_RST;
      last_trap <= 32'h0000_0000;
      xfer_cnt  <= 32'h0000_0000;
      prdata    <= 32'h0000_0000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      irq       <= 1'b0;
    end else begin
      ctrl      <= next_ctrl;
      int_stat  <= next_int_stat;
      int_mask  <= next_int_mask;
      last_trap <= next_last_trap;
      xfer_cnt  <= next_xfer_cnt;
      prdata    <= next_prdata;
      pready    <= next_pready;
      pslverr   <= next_pslverr;
      irq       <= next_irq;
    end
  end

endmodule

// ### design/crt_pkg.sv
// Package with constants and types of the coprocessor register transfer unit
package crt_pkg;

  // Instruction field positions
  localparam int COND_MSB      = 31;  // Condition field top bit
  localparam int COND_LSB      = 28;  // Condition field bottom bit
  localparam int CLASS_MSB     = 27;  // Instruction class top bit
  localparam int CLASS_LSB     = 24;  // Instruction class bottom bit
  localparam int OPC_MSB       = 23;  // Operation code field top bit
  localparam int OPC_LSB       = 21;  // Operation code field bottom bit
  localparam int DIR_BIT       = 20;  // Direction bit, 1 = move to core
  localparam int CRN_MSB       = 19;  // First coproc register top bit
  localparam int CRN_LSB       = 16;  // First coproc register bottom bit
  localparam int RD_MSB        = 15;  // Core register top bit
  localparam int RD_LSB        = 12;  // Core register bottom bit
  localparam int CPN_MSB       = 11;  // Coproc number top bit
  localparam int CPN_LSB       = 8;   // Coproc number bottom bit
  localparam int VAR_MSB       = 7;   // Operation variant top bit
  localparam int VAR_LSB       = 5;   // Operation variant bottom bit
  localparam int XFER_BIT      = 4;   // Set for register transfer class
  localparam int CRM_MSB       = 3;   // Second coproc register top bit
  localparam int CRM_LSB       = 0;   // Second coproc register bottom bit
  localparam int UND_MSB       = 27;  // Undefined pattern class top bit
  localparam int UND_LSB       = 25;  // Undefined pattern class bottom bit

  // Encodings
  localparam logic [3:0] CLASS_COPROC   = 4'he;  // Coprocessor class value
  localparam logic [2:0] CLASS_UNDEF    = 3'h3;  // Undefined pattern class
  localparam logic [3:0] CP_INTERNAL    = 4'hf;  // Internal control coproc
  localparam logic [3:0] PC_INDEX       = 4'hf;  // Program counter register
  localparam logic [3:0] CP15_REG_LIMIT = 4'h7;  // Highest serviced register
  localparam logic [31:0] PC_STORE_OFFSET = 32'h0000_000c;  // Stored value offset

  // Timing
  localparam int INTERNAL_CYCLES = 3;  // Internal cycles of a serviced transfer

  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL     = 8'h00;  // Control
  localparam logic [7:0] OFF_INT_STAT = 8'h04;  // Sticky event status
  localparam logic [7:0] OFF_INT_MASK = 8'h08;  // Interrupt mask
  localparam logic [7:0] OFF_LAST_TRAP = 8'h0c; // Last trapped instruction
  localparam logic [7:0] OFF_XFER_CNT = 8'h10;  // Serviced transfer count

  // Control field and event bit positions
  localparam int CTRL_HW_EN   = 0;  // Internal coproc servicing enable
  localparam int EV_TRAP      = 0;  // Undefined trap taken
  localparam int EV_DONE      = 1;  // Hardware transfer completed
  localparam int EV_SKIP      = 2;  // Condition failed, no effect
  localparam int EV_W         = 3;  // Event field width

  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;  // Servicing enabled
  localparam logic [2:0]  MASK_RST = 3'h0;           // All events masked

  // Transfer sequencer states
  typedef enum logic [2:0] {
    CRT_IDLE,
    CRT_EX1,
    CRT_EX2,
    CRT_EX3,
    CRT_RESP
  } crt_state_t;

endpackage

// ### design/crt_cond.sv
// Condition field evaluator against the current flags
`timescale 1ns/1ps
module crt_cond (
  input  wire logic [3:0] cond,   // Condition field
  input  wire logic [3:0] flags,  // Flags as negative, zero, carry, overflow
  output logic            pass    // Condition holds
);

  logic n;  // Negative flag
  logic z;  // Zero flag
  logic c;  // Carry flag
  logic v;  // Overflow flag

  assign n = flags[3];
  assign z = flags[2];
  assign c = flags[1];
  assign v = flags[0];

  // Sixteen condition codes
  always_comb begin
    case (cond)
      4'h0: pass = z;
      4'h1: pass = !z;
      4'h2: pass = c;
      4'h3: pass = !c;
      4'h4: pass = n;
      4'h5: pass = !n;
      4'h6: pass = v;
      4'h7: pass = !v;
      4'h8: pass = c && !z;
      4'h9: pass = !c || z;
      4'ha: pass = (n == v);
      4'hb: pass = (n != v);
      4'hc: pass = !z && (n == v);
      4'hd: pass = z || (n != v);
      4'he: pass = 1'b1;
      default: pass = 1'b0;  // Never
    endcase
  end

endmodule

// ### dv/crt_assertions.sv
// Checker of the transfer unit port behaviour
`timescale 1ns/1ps
module crt_assertions (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        instr_valid,
  input wire logic        instr_ready,
  input wire logic [31:0] instr_word,
  input wire logic [31:0] instr_addr,
  input wire logic [31:0] core_rd_value,
  input wire logic [3:0]  core_flags,
  input wire logic        xfer_done,
  input wire logic        undef_trap,
  input wire logic        core_wr_en,
  input wire logic        flags_wr_en,
  input wire logic [3:0]  flags_wr_data,
  input wire logic        cp15_rd_en,
  input wire logic        cp15_wr_en,
  input wire logic [3:0]  cp15_reg,
  input wire logic [2:0]  cp15_opc,
  input wire logic [2:0]  cp15_var,
  input wire logic [3:0]  cp15_crm,
  input wire logic [31:0] cp15_wdata,
  input wire logic [31:0] cp15_rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic acc;  // Instruction taken
  logic al;   // Always-true condition
  logic xs;   // Internal coproc strobe
  assign acc = instr_valid && instr_ready;
  assign al  = instr_word[31:28] == 4'he;
  assign xs  = cp15_rd_en || cp15_wr_en;
  AST_OTHER_CP: assert property (
    acc && al && instr_word[27:24] == 4'he && instr_word[4] && instr_word[11:8] != 4'hf
    |=> undef_trap) else $error("other coprocessor not trapped");
  AST_COND_SKIP: assert property (
    acc && instr_word[31:28] == 4'h0 && !core_flags[2]
    |=> xfer_done && !undef_trap && !core_wr_en && !flags_wr_en) else $error("skip wrong");
  AST_UNDEF: assert property (
    acc && al && instr_word[27:25] == 3'h3 && instr_word[4] |=> undef_trap)
    else $error("undefined pattern not trapped");
  AST_HW_TIME: assert property (
    xs |=> !xfer_done ##1 xfer_done) else $error("transfer length wrong");
  AST_ROUTE: assert property (
    xs |-> $past(instr_word[11:8]) == 4'hf && cp15_reg <= 4'h7) else $error("bad routing");
  AST_DIR: assert property (
    xs |-> cp15_rd_en == $past(instr_word[20]) && !(cp15_rd_en && cp15_wr_en))
    else $error("direction wrong");
  AST_FIELDS: assert property (
    xs |-> {cp15_opc, cp15_reg, cp15_var, cp15_crm} == $past({instr_word[23:21],
    instr_word[19:16], instr_word[7:5], instr_word[3:0]})) else $error("fields altered");
  AST_PC_STORE: assert property (
    cp15_wr_en |-> cp15_wdata == ($past(instr_word[15:12]) == 4'hf ?
    $past(instr_addr) + 32'h0000_000c : $past(core_rd_value))) else $error("wdata wrong");
  AST_FLAGS: assert property (
    flags_wr_en |-> xfer_done && !core_wr_en && flags_wr_data == $past(cp15_rdata[31:28], 2))
    else $error("flag load wrong");
  AST_TRAP_QUIET: assert property (
    undef_trap |-> xfer_done && !core_wr_en && !flags_wr_en && !xs)
    else $error("trap changed state");
endmodule

bind crt_unit crt_assertions i_chk (.clk, .nrst, .instr_valid, .instr_ready, .instr_word,
  .instr_addr, .core_rd_value, .core_flags, .xfer_done, .undef_trap, .core_wr_en,
  .flags_wr_en, .flags_wr_data, .cp15_rd_en, .cp15_wr_en, .cp15_reg, .cp15_opc,
  .cp15_var, .cp15_crm, .cp15_wdata, .cp15_rdata);

// ### dv/crt_cp15_model.sv
// Behavioural model of the internal control coprocessor
`timescale 1ns/1ps
module crt_cp15_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        cp15_rd_en,
  input  wire logic        cp15_wr_en,
  input  wire logic [3:0]  cp15_reg,
  input  wire logic [31:0] cp15_wdata,
  output logic [31:0]      cp15_rdata
);
  logic [31:0] regs [8];  // Control registers 0 to 7
  // Answers at once while read, inverted junk otherwise
  assign cp15_rdata = cp15_rd_en ? regs[cp15_reg[2:0]] : ~regs[cp15_reg[2:0]];
  // Stores written values, field meaning is ours alone
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 8; i++) begin
        regs[i] <= 32'h0000_0000;
      end
    end else if (cp15_wr_en) begin
      regs[cp15_reg[2:0]] <= cp15_wdata;
    end
  end
endmodule

// ### dv/crt_tb.sv
// Self-checking bench of the coprocessor register transfer unit
`timescale 1ns/1ps
module testbench;
  logic        clk, nrst, instr_valid, instr_ready, xfer_done, undef_trap, core_wr_en;
  logic        flags_wr_en, cp15_rd_en, cp15_wr_en, psel, penable, pwrite, pready;
  logic        pslverr, irq, hw_en, err;
  logic [2:0]  cp15_opc, cp15_var;
  logic [3:0]  core_flags, core_wr_idx, flags_wr_data, cp15_reg, cp15_crm;
  logic [7:0]  paddr;
  logic [31:0] instr_word, instr_addr, core_rd_value, core_wr_data, cp15_wdata;
  logic [31:0] cp15_rdata, pwdata, prdata, rd, w, r;
  logic [31:0] mirror [8];
  logic [31:0] corner [8] = '{32'hee03_ff10, 32'hee13_ff10, 32'hee17_2f10, 32'hee08_2f10,
                              32'hee13_2e10, 32'he600_0010, 32'h0600_0010, 32'h0e03_2f10};
  int          n_errors, samples_checked, seed, hw_count;

  crt_unit i_dut (.clk, .nrst, .instr_valid, .instr_ready, .instr_word, .instr_addr,
    .core_rd_value, .core_flags, .xfer_done, .undef_trap, .core_wr_en, .core_wr_idx,
    .core_wr_data, .flags_wr_en, .flags_wr_data, .cp15_rd_en, .cp15_wr_en, .cp15_reg,
    .cp15_opc, .cp15_var, .cp15_crm, .cp15_wdata, .cp15_rdata, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .irq);
  crt_cp15_model i_cp15 (.clk, .nrst, .cp15_rd_en, .cp15_wr_en, .cp15_reg, .cp15_wdata,
    .cp15_rdata);

  // Clock of 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Counts and reports one comparison
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic end_of_test;
    if (n_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Condition evaluation on flags N Z C V
  function automatic logic cpass(input logic [3:0] c, input logic [3:0] f);
    logic t;
    case (c[3:1])
      3'h0: t = f[2];
      3'h1: t = f[1];
      3'h2: t = f[3];
      3'h3: t = f[0];
      3'h4: t = f[1] & ~f[2];
      3'h5: t = f[3] == f[0];
      3'h6: t = ~f[2] & (f[3] == f[0]);
      default: t = 1'b1;
    endcase
    return t ^ c[0];
  endfunction

  // Expected outcome: 0 skip, 1 trap, 2 hardware transfer
  function automatic logic [1:0] kind(input logic [31:0] x, input logic [3:0] f);
    if (!cpass(x[31:28], f))
      return 2'h0;
    if (x[27:24] == 4'he && x[4] && x[11:8] == 4'hf && x[19:16] <= 4'h7 && hw_en)
      return 2'h2;
    return 2'h1;
  endfunction

  // One APB transfer, result in rd and err
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (!pready && k < 20);
    if (!pready) n_errors++;
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Offers one instruction and checks its outcome
  task automatic issue(input logic [31:0] x, a, v, input logic [3:0] f);
    int n;
    logic [1:0] kd;
    kd = kind(x, f);
    @(posedge clk);
    instr_valid   <= 1'b1;
    instr_word    <= x;
    instr_addr    <= a;
    core_rd_value <= v;
    core_flags    <= f;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!instr_ready && n < 20);
    if (!instr_ready) n_errors++;
    instr_valid   <= 1'b0;
    instr_word    <= ~x;
    core_rd_value <= ~v;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!xfer_done && n < 8);
    chk(n, kd == 2'h2 ? 3 : 1);
    chk(undef_trap, kd == 2'h1);
    chk(core_wr_en, kd == 2'h2 && x[20] && x[15:12] != 4'hf);
    chk(flags_wr_en, kd == 2'h2 && x[20] && x[15:12] == 4'hf);
    if (kd == 2'h2 && x[20] && x[15:12] != 4'hf) begin
      chk(core_wr_data, mirror[x[18:16]]);
      chk(core_wr_idx, x[15:12]);
    end
    if (kd == 2'h2 && x[20] && x[15:12] == 4'hf)
      chk(flags_wr_data, mirror[x[18:16]][31:28]);
    if (kd == 2'h2 && !x[20])
      mirror[x[18:16]] = x[15:12] == 4'hf ? a + 32'h0000_000c : v;
    if (kd == 2'h2)
      hw_count++;
  endtask

  // Watchdog
  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    end_of_test();
  end

  initial begin
    {n_errors, samples_checked, hw_count} = '0;
    seed = 84590;
    {nrst, instr_valid, psel, penable, pwrite} = '0;
    {instr_word, instr_addr, core_rd_value, pwdata, paddr, core_flags} = '0;
    hw_en = 1'b1;
    for (int i = 0; i < 8; i++) begin
      mirror[i] = 32'h0000_0000;
    end
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, crt_pkg::OFF_CTRL, 32'h0000_0000);
    chk(rd, crt_pkg::CTRL_RST);
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk({err, rd[30:0]}, 32'h8000_0000);
    // Corner words, all with flags clear
    for (int i = 0; i < 8; i++) begin
      issue(corner[i], 32'ha000_0000, $random(seed), 4'h0);
    end
    // Events, mask and level interrupt
    apb(1'b0, crt_pkg::OFF_INT_STAT, 32'h0000_0000);
    chk(rd, 32'h0000_0007);
    apb(1'b1, crt_pkg::OFF_INT_STAT, 32'h0000_0007);
    issue(corner[4], 32'h0000_0100, 32'h0000_0000, 4'h0);
    apb(1'b0, crt_pkg::OFF_INT_STAT, 32'h0000_0000);
    chk({irq, rd[2:0]}, 32'h0000_0001);
    apb(1'b0, crt_pkg::OFF_LAST_TRAP, 32'h0000_0000);
    chk(rd, corner[4]);
    apb(1'b1, crt_pkg::OFF_INT_MASK, 32'h0000_0001);
    @(posedge clk);
    chk(irq, 1'b1);
    apb(1'b1, crt_pkg::OFF_INT_STAT, 32'h0000_0001);
    @(posedge clk);
    chk(irq, 1'b0);
    // Servicing disabled makes internal transfers trap
    apb(1'b1, crt_pkg::OFF_CTRL, 32'h0000_0000);
    hw_en = 1'b0;
    issue(corner[2], 32'h0000_0000, 32'h0000_0000, 4'h0);
    apb(1'b1, crt_pkg::OFF_CTRL, 32'h0000_0001);
    hw_en = 1'b1;
    // Random transfers
    repeat (200) begin
      w = $random(seed);
      r = $random(seed);
      w[27:24] = 4'he;
      w[4] = 1'b1;
      if (r[4])
        w[11:8] = 4'hf;
      if (r[5] || w[31:28] == 4'hf)
        w[31:28] = 4'he;
      issue(w, $random(seed), $random(seed), r[3:0]);
    end
    apb(1'b0, crt_pkg::OFF_XFER_CNT, 32'h0000_0000);
    chk(rd, hw_count);
    end_of_test();
  end
endmodule
